//--- core/pcpos_defs.svh
/*
 * Register offsets, command opcodes and packet sizes of the packet
 * command sequencer. Assumes byte addressing on a 32-bit APB bus.
 */
`ifndef PCPOS_DEFS_SVH
`define PCPOS_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define PCPOS_A_DATA    8'h00
`define PCPOS_A_FEAT    8'h04
`define PCPOS_A_IRSN    8'h08
`define PCPOS_A_BCL     8'h10
`define PCPOS_A_BCH     8'h14
`define PCPOS_A_DRVH    8'h18
`define PCPOS_A_STCMD   8'h1c
`define PCPOS_A_CTRL    8'h20

// ==========================================================================
// Opcodes and packet lengths in 16-bit words
`define PCPOS_OP_PACKET 8'ha0
`define PCPOS_OP_SERV   8'ha2
`define PCPOS_PKT12_W   4'h6
`define PCPOS_PKT16_W   4'h8

// ==========================================================================
// Control register fields and reset values
`define PCPOS_CTL_PKT16 0
`define PCPOS_CTL_PKINT 1
`define PCPOS_CTL_RST   2'h0

`endif

//--- core/pcpos_pkg.sv
/*
 * Types of the packet command sequencer: status layout, interrupt
 * reason layout and sequencer states. Assumes nothing else.
 */
package pcpos_pkg;

    // ======================================================================
    // Status register image
    typedef struct packed {
        logic       bsy;
        logic       drdy;
        logic       rsv5;
        logic       serv;
        logic       drq;
        logic [1:0] rsv21;
        logic       err;
    } pcpos_stat_t;

    // ======================================================================
    // Interrupt reason image
    typedef struct packed {
        logic rel;
        logic io;
        logic cod;
    } pcpos_irsn_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMDB,
        ST_PKT,
        ST_EXEC,
        ST_DATA,
        ST_REL,
        ST_SVCW,
        ST_SVCG
    } pcpos_state_t;

endpackage

//--- core/pcpos_seq.sv
/*
 * Device-side sequencer for a packet command with PIO data out, plus
 * the service tail of the overlapped flow. The host reaches the task
 * file over APB; the device back end sits on the plain be_ ports, inputs and outputs.
 * Assumes all inputs are synchronous to pclk.
 */
`timescale 1ns/100ps
`include "pcpos_defs.svh"

module pcpos_seq
    import pcpos_pkg::*;
#(
    parameter int BCW = 16
)(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    output logic                dev_intrq,
    input  wire logic           be_pkt_ready,
    input  wire logic           be_burst,
    input  wire logic [BCW-1:0] be_burst_cnt,
    input  wire logic           be_done,
    input  wire logic           be_err,
    input  wire logic [7:0]     be_err_code,
    input  wire logic           be_release,
    input  wire logic           be_svc_ready,
    input  wire logic [15:0]    be_rdata,
    output logic                be_wvalid,
    output logic                be_wpkt,
    output logic [15:0]         be_wdata,
    output logic                be_rtake,
    output logic                be_cmd_ready,
    output logic [7:0]          be_feat,
    output logic [15:0]         be_bcount
);

    if (BCW < 2 || BCW > 16)
    begin : g_chk
        $error("pcpos_seq: BCW must be 2..16");
    end

    // ======================================================================
    // Address decode
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `PCPOS_A_DATA) || (a == `PCPOS_A_FEAT)
              || (a == `PCPOS_A_IRSN) || (a == `PCPOS_A_BCL)
              || (a == `PCPOS_A_BCH)  || (a == `PCPOS_A_DRVH)
              || (a == `PCPOS_A_STCMD) || (a == `PCPOS_A_CTRL);
    endfunction

    pcpos_state_t state_reg;
    pcpos_stat_t  stat_reg;
    pcpos_irsn_t  irsn_reg;
    logic [7:0]   err_reg;
    logic [7:0]   feat_reg;
    logic [7:0]   bcl_reg;
    logic [7:0]   bch_reg;
    logic [7:0]   drvh_reg;
    logic [1:0]   ctrl_reg;
    logic [3:0]   wcnt_reg;
    logic [BCW:0] rem_reg;
    logic         pready_reg;
    logic         acc;
    logic         wr;
    logic         stat_rd;
    logic         data_acc;
    logic         cmd_wr;
    logic [3:0]   pkt_words;
    logic [31:0]  rd_val;

    // A transfer completes on the edge where pready is already high,
    // giving one fixed wait state so prdata can come from a flop.
    assign acc      = psel & penable & pready_reg;
    assign wr       = acc & pwrite;
    assign stat_rd  = acc & ~pwrite & (paddr == `PCPOS_A_STCMD);
    assign cmd_wr   = wr & (paddr == `PCPOS_A_STCMD);
    // Direction follows IO: writes when clear, reads when set
    assign data_acc = acc & (paddr == `PCPOS_A_DATA) & stat_reg.drq
                    & (pwrite != irsn_reg.io);
    assign pkt_words = ctrl_reg[`PCPOS_CTL_PKT16] ? `PCPOS_PKT16_W
                                                  : `PCPOS_PKT12_W;

    // ======================================================================
    // APB read mux
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (paddr)
            `PCPOS_A_DATA:  rd_val = {16'h0000, be_rdata};
            `PCPOS_A_FEAT:  rd_val = {24'h000000, err_reg};
            `PCPOS_A_IRSN:  rd_val = {29'h0, irsn_reg};
            `PCPOS_A_BCL:   rd_val = {24'h000000, bcl_reg};
            `PCPOS_A_BCH:   rd_val = {24'h000000, bch_reg};
            `PCPOS_A_DRVH:  rd_val = {24'h000000, drvh_reg};
            // DRQ masked while busy so the host never sees both
            `PCPOS_A_STCMD: rd_val = {24'h000000, stat_reg.bsy, stat_reg.drdy,
                                      1'b0, stat_reg.serv,
                                      stat_reg.drq & ~stat_reg.bsy,
                                      2'b00, stat_reg.err};
            `PCPOS_A_CTRL:  rd_val = {30'h0, ctrl_reg};
            default:        rd_val = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // APB handshake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
        end
        else
        begin
            pready_reg <= psel & penable & ~pready_reg;
            if (psel & penable & ~pready_reg)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= ~mapped(paddr);
            end
        end
    end
    assign pready = pready_reg;

    // ======================================================================
    // Host-written task file and control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feat_reg <= 8'h00;
            drvh_reg <= 8'h00;
            ctrl_reg <= `PCPOS_CTL_RST;
        end
        else if (wr)
        begin
            case (paddr)
                `PCPOS_A_FEAT: feat_reg <= pwdata[7:0];
                `PCPOS_A_DRVH: drvh_reg <= pwdata[7:0];
                `PCPOS_A_CTRL: ctrl_reg <= pwdata[1:0];
                default:       ;
            endcase
        end
    end

    // ======================================================================
    // Data path toward the back end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            be_wvalid <= 1'b0;
            be_wpkt   <= 1'b0;
            be_wdata  <= 16'h0000;
            be_rtake  <= 1'b0;
        end
        else
        begin
            be_wvalid <= data_acc & pwrite;
            be_wpkt   <= data_acc & pwrite & (state_reg == ST_PKT);
            be_rtake  <= data_acc & ~pwrite;
            if (data_acc & pwrite)
                be_wdata <= pwdata[15:0];
        end
    end

    // ======================================================================
    // Protocol sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= ST_IDLE;
            stat_reg     <= '0;
            irsn_reg     <= '0;
            err_reg      <= 8'h00;
            bcl_reg      <= 8'h00;
            bch_reg      <= 8'h00;
            wcnt_reg     <= 4'h0;
            rem_reg      <= '0;
            dev_intrq    <= 1'b0;
            be_cmd_ready <= 1'b0;
            be_feat      <= 8'h00;
            be_bcount    <= 16'h0000;
        end
        else
        begin
            be_cmd_ready <= 1'b0;
            // Any later set in this cycle overrides the clear
            if (stat_rd)
                dev_intrq <= 1'b0;
            if (wr && paddr == `PCPOS_A_BCL && !stat_reg.bsy)
                bcl_reg <= pwdata[7:0];
            if (wr && paddr == `PCPOS_A_BCH && !stat_reg.bsy)
                bch_reg <= pwdata[7:0];
            case (state_reg)
                ST_IDLE:
                begin
                    if (cmd_wr && pwdata[7:0] == `PCPOS_OP_PACKET)
                    begin
                        stat_reg.bsy <= 1'b1;
                        stat_reg.err <= 1'b0;
                        irsn_reg.rel <= 1'b0;
                        state_reg    <= ST_CMDB;
                    end
                end
                ST_CMDB:
                begin
                    if (be_pkt_ready)
                    begin
                        irsn_reg.cod <= 1'b1;
                        irsn_reg.io  <= 1'b0;
                        stat_reg.bsy <= 1'b0;
                        stat_reg.drq <= 1'b1;
                        wcnt_reg     <= 4'h0;
                        if (ctrl_reg[`PCPOS_CTL_PKINT])
                            dev_intrq <= 1'b1;
                        state_reg    <= ST_PKT;
                    end
                end
                ST_PKT:
                begin
                    if (data_acc)
                    begin
                        wcnt_reg <= wcnt_reg + 4'h1;
                        if (wcnt_reg + 4'h1 == pkt_words)
                        begin
                            stat_reg.drq <= 1'b0;
                            stat_reg.bsy <= 1'b1;
                            be_feat      <= feat_reg;
                            be_bcount    <= {bch_reg, bcl_reg};
                            be_cmd_ready <= 1'b1;
                            state_reg    <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC:
                begin
                    if (be_done)
                    begin
                        err_reg       <= be_err_code;
                        stat_reg.err  <= be_err;
                        stat_reg.drdy <= 1'b1;
                        stat_reg.bsy  <= 1'b0;
                        stat_reg.drq  <= 1'b0;
                        irsn_reg      <= '{rel: 1'b0, io: 1'b1, cod: 1'b1};
                        dev_intrq     <= 1'b1;
                        state_reg     <= ST_IDLE;
                    end
                    else if (be_burst)
                    begin
                        {bch_reg, bcl_reg} <= 16'(be_burst_cnt);
                        rem_reg      <= {1'b0, be_burst_cnt};
                        irsn_reg.cod <= 1'b0;
                        irsn_reg.io  <= 1'b0;
                        stat_reg.drq <= 1'b1;
                        stat_reg.bsy <= 1'b0;
                        dev_intrq    <= 1'b1;
                        state_reg    <= ST_DATA;
                    end
                    else if (be_release)
                    begin
                        irsn_reg     <= '{rel: 1'b1, io: 1'b0, cod: 1'b0};
                        stat_reg.bsy <= 1'b0;
                        dev_intrq    <= 1'b1;
                        state_reg    <= ST_REL;
                    end
                end
                ST_DATA:
                begin
                    if (data_acc)
                    begin
                        // An odd count ends on a word carrying one byte
                        if (rem_reg <= (BCW+1)'(2))
                        begin
                            stat_reg.drq <= 1'b0;
                            stat_reg.bsy <= 1'b1;
                            state_reg    <= ST_EXEC;
                        end
                        else
                            rem_reg <= rem_reg - (BCW+1)'(2);
                    end
                end
                ST_REL:
                begin
                    if (be_svc_ready)
                    begin
                        stat_reg.serv <= 1'b1;
                        dev_intrq     <= 1'b1;
                        state_reg     <= ST_SVCW;
                    end
                end
                ST_SVCW:
                begin
                    if (cmd_wr && pwdata[7:0] == `PCPOS_OP_SERV)
                    begin
                        stat_reg.bsy <= 1'b1;
                        state_reg    <= ST_SVCG;
                    end
                end
                ST_SVCG:
                begin
                    {bch_reg, bcl_reg} <= 16'(be_burst_cnt);
                    rem_reg       <= {1'b0, be_burst_cnt};
                    stat_reg.drq  <= 1'b1;
                    stat_reg.serv <= 1'b0;
                    stat_reg.bsy  <= 1'b0;
                    irsn_reg      <= '{rel: 1'b0, io: 1'b1, cod: 1'b0};
                    dev_intrq     <= 1'b1;
                    state_reg     <= ST_DATA;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule // pcpos_seq

//--- bench/pcpos_seq_properties.sv
/*
 * Port assertions of the packet command sequencer, bound into pcpos_seq.
 * Assumes one wait state on APB and back-end events that arrive only in
 * the states where the back end may raise them.
 */
`timescale 1ns/100ps
module pcpos_seq_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        dev_intrq,
    input wire logic        be_burst,
    input wire logic        be_done,
    input wire logic        be_release,
    input wire logic        be_svc_ready,
    input wire logic        be_wvalid,
    input wire logic [15:0] be_wdata,
    input wire logic        be_rtake,
    input wire logic        be_cmd_ready
);
    logic acc, dwr, srd, map, bev;
    assign acc = psel && penable && pready;
    assign dwr = acc && pwrite && paddr == 8'h00;
    assign srd = acc && !pwrite && paddr == 8'h1c;
    assign map = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    assign bev = be_burst || be_done || be_release || be_svc_ready;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ======================================================================
    // Bus answer
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not raised after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_unmapped_err: assert property (pready && !map |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && map |-> !pslverr)
        else $error("error on mapped access");

    // ======================================================================
    // Sequencer
    a_stat_no_drq: assert property (srd |-> !(prdata[7] && prdata[3]))
        else $error("status shows data request while busy");
    a_read_clears: assert property (srd && !bev |=> !dev_intrq)
        else $error("status read left the interrupt raised");
    a_event_irq: assert property (be_burst || be_done |=> dev_intrq)
        else $error("no interrupt after burst or completion");
    a_last_word: assert property (be_cmd_ready |-> $past(dwr) ##1 !be_cmd_ready)
        else $error("packet end without a data write");
    a_word_taken: assert property (be_wvalid |-> $past(dwr) && be_wdata == $past(pwdata[15:0]))
        else $error("data word not from an accepted write");
    a_take_read: assert property (be_rtake |-> $past(acc && !pwrite && paddr == 8'h00))
        else $error("data word taken without a read");
endmodule // pcpos_seq_properties

bind pcpos_seq pcpos_seq_properties i_pcpos_seq_properties (.*);

//--- bench/pcpos_be_model.sv
/*
 * Back-end model of the sequencer: raises one event pulse on command
 * and counts the words handed over. Assumes commands on pclk edges.
 */
`timescale 1ns/100ps
module pcpos_be_model (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ev_go,
    input wire logic [1:0] ev_sel,
    input wire logic       be_wvalid,
    input wire logic       be_wpkt,
    output logic           be_burst,
    output logic           be_done,
    output logic           be_release,
    output logic           be_svc_ready,
    output logic [4:0]     pkt_words,
    output logic [4:0]     data_words
);
    // ======================================================================
    // One-cycle events, so a second event is never seen by accident
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {be_burst, be_done, be_release, be_svc_ready} <= 4'h0;
        else
        begin
            be_burst     <= ev_go && ev_sel == 2'h0;
            be_done      <= ev_go && ev_sel == 2'h1;
            be_release   <= ev_go && ev_sel == 2'h2;
            be_svc_ready <= ev_go && ev_sel == 2'h3;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {pkt_words, data_words} <= 10'h0;
        else if (be_wvalid)
        begin
            pkt_words  <= pkt_words + 5'(be_wpkt);
            data_words <= data_words + 5'(!be_wpkt);
        end
    end
endmodule // pcpos_be_model

//--- bench/packet_cmd_pio_out_sequencer_tb_top.sv
/*
 * Self-checking bench of the sequencer: the bench is the APB host, the
 * model stands for the back end. Assumes pready answers in time.
 */
`timescale 1ns/100ps
module packet_cmd_pio_out_sequencer_tb_top;
    import pcpos_pkg::*;
    typedef struct packed {
        logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;
    } pcpos_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00, be_err_code = 8'h00, be_feat;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic dev_intrq, be_pkt_ready = 0, be_err = 0, be_burst, be_done, be_release;
    logic be_svc_ready, be_wvalid, be_wpkt, be_rtake, be_cmd_ready, ev_go = 0, e;
    logic [15:0] be_burst_cnt = 16'h0004, be_rdata = 16'h0000, be_wdata, be_bcount;
    logic [1:0] ev_sel = 2'h0;
    logic [4:0] pkt_words, data_words, base;
    int miscompares = 0, checks = 0, cyc = 0, i;
    pcpos_row_t rows [9] = '{
        '{0, 8'h1c, 0, 0, 0}, '{0, 8'h08, 0, 0, 0}, '{0, 8'h20, 0, 0, 0},
        '{0, 8'h0c, 0, 0, 1}, '{1, 8'h24, 5, 0, 1}, '{1, 8'h10, 32'h34, 0, 0},
        '{0, 8'h10, 0, 32'h34, 0}, '{1, 8'h14, 32'h12, 0, 0}, '{0, 8'h14, 0, 32'h12, 0}};

    pcpos_seq i_pcpos_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .dev_intrq(dev_intrq), .be_pkt_ready(be_pkt_ready),
        .be_burst(be_burst), .be_burst_cnt(be_burst_cnt), .be_done(be_done), .be_err(be_err),
        .be_err_code(be_err_code), .be_release(be_release), .be_svc_ready(be_svc_ready),
        .be_rdata(be_rdata), .be_wvalid(be_wvalid), .be_wpkt(be_wpkt), .be_wdata(be_wdata),
        .be_rtake(be_rtake), .be_cmd_ready(be_cmd_ready), .be_feat(be_feat),
        .be_bcount(be_bcount));
    pcpos_be_model i_pcpos_be_model (.pclk(pclk), .presetn(presetn), .ev_go(ev_go),
        .ev_sel(ev_sel), .be_wvalid(be_wvalid), .be_wpkt(be_wpkt), .be_burst(be_burst),
        .be_done(be_done), .be_release(be_release), .be_svc_ready(be_svc_ready),
        .pkt_words(pkt_words), .data_words(data_words));

    always #10 pclk = ~pclk;
    // The whole run needs about 450 cycles; the ceiling leaves ample slack
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ======================================================================
    // Helpers
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        // Start on a rising edge; back-to-back calls then never drive psel twice at once
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(0, a, 0);
        chk(r & m, x);
    endtask
    task automatic waiti();
        for (int n = 0; n < 20 && dev_intrq !== 1'b1; n++)
            @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, dev_intrq}, 32'h1);
    endtask
    task automatic ev(input logic [1:0] s);
        ev_sel <= s;
        ev_go <= 1;
        @(posedge pclk);
        ev_go <= 0;
        waiti();
    endtask
    task automatic pkt(input logic p16);
        be_pkt_ready <= 0;
        wr(8'h20, {30'h0, p16, p16});
        wr(8'h04, 32'h5a); wr(8'h10, 32'h04); wr(8'h14, 32'h00); wr(8'h18, 32'h00);
        wr(8'h1c, 32'ha0);
        rdc(8'h1c, 32'hbf, 32'h80);
        wr(8'h00, 32'h1111);
        base = pkt_words;
        be_pkt_ready <= 1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, dev_intrq}, {31'h0, p16});
        rdc(8'h1c, 32'hbf, 32'h08);
        rdc(8'h08, 32'h7, 32'h1);
        for (i = 0; i < (p16 ? 7 : 5); i++)
            wr(8'h00, i);
        repeat (2) @(negedge pclk);
        chk(5'(pkt_words - base), p16 ? 7 : 5);
        wr(8'h00, 32'hffff);
        rdc(8'h1c, 32'hbf, 32'h80);
        chk({be_bcount, be_feat}, 32'h0004_5a);
        chk(5'(pkt_words - base), p16 ? 8 : 6);
    endtask
    task automatic burst_done(input logic err);
        base = data_words;
        ev(2'h0);
        rdc(8'h10, 32'hff, 32'h04);
        rdc(8'h08, 32'h7, 32'h0);
        rdc(8'h1c, 32'hbf, 32'h08);
        @(negedge pclk);
        chk({31'h0, dev_intrq}, 32'h0);
        wr(8'h00, 32'h0101); wr(8'h00, 32'h0202);
        rdc(8'h1c, 32'hbf, 32'h80);
        wr(8'h00, 32'h0303);
        be_err <= err;
        be_err_code <= 8'h3c;
        repeat (2) @(negedge pclk);
        chk(5'(data_words - base), 5'h2);
        chk({16'h0, be_wdata}, 32'h0202);
        @(posedge pclk);
        ev(2'h1);
        rdc(8'h1c, 32'hff, {24'h0, 7'h20, err});
        rdc(8'h08, 32'h7, 32'h3);
        rdc(8'h04, 32'hff, 32'h3c);
        be_err <= 0;
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rows[k])
        begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            chk(r & {32{!rows[k].w}}, rows[k].q);
            chk({31'h0, e}, {31'h0, rows[k].e});
        end
        $display("register table done");
        pkt(0);
        burst_done(1);
        $display("12-byte packet with error done");
        pkt(1);
        burst_done(0);
        $display("16-byte packet done");
        // Release and service: the data-in tail of the overlapped flow
        pkt(0);
        ev(2'h2);
        rdc(8'h1c, 32'h98, 32'h0);
        rdc(8'h08, 32'h7, 32'h4);
        ev(2'h3);
        rdc(8'h1c, 32'h10, 32'h10);
        be_burst_cnt <= 16'h0002;
        be_rdata <= 16'hbeef;
        wr(8'h1c, 32'ha2);
        waiti();
        rdc(8'h08, 32'h7, 32'h2);
        rdc(8'h10, 32'hff, 32'h02);
        rdc(8'h1c, 32'h18, 32'h08);
        rdc(8'h00, 32'hffff, 32'hbeef);
        $display("release and service done");
        // Reset after the command has completed, with its interrupt pending
        ev(2'h1);
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        chk({31'h0, dev_intrq}, 32'h0);
        rdc(8'h1c, 32'hff, 32'h00);
        rdc(8'h08, 32'h7, 32'h0);
        $display("mid-run reset done");
        conclude();
    end
endmodule // packet_cmd_pio_out_sequencer_tb_top
